// file: dma_channel.sv
`timescale 1ns/1ps
module dma_channel #(
  parameter int SIZE_W = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic irq_valid,
  input wire logic [7:0] irq_num,
  input wire logic pattern_match,
  input wire logic mv_ack,
  input wire logic mv_err,
  output logic mv_req,
  output dma_chan_pkg::move_req_t mv_addr,
  output logic chan_irq
);

  if (SIZE_W != dma_chan_pkg::SIZE_BITS) begin : g_chk
    $error("dma_channel: SIZE_W must match the 16-bit size fields");
  end

  dma_chan_pkg::chan_state_t st_r;
  dma_chan_pkg::chan_state_t st_nxt;
  logic [15:0] sptr;
  logic [15:0] sptr_nxt;
  logic [15:0] dptr;
  logic [15:0] dptr_nxt;
  logic start;
  logic step;
  logic bus_wr;
  logic [4:0] ev;
  logic [15:0] big_size;
  logic [16:0] lim;
  logic [16:0] total_inc;
  logic [16:0] cell_inc;
  logic [16:0] dptr_inc;
  logic busy;
  logic [16:0] half_pt;
  logic abort_hit;
  logic match_hit;

  // ---------------------------------------------------------------
  // Source and destination byte pointers
  // ---------------------------------------------------------------
  // Both clear on start and step together; each wraps at its own size
  byte_pointer #(.PTR_W(16)) u_src_ptr (
    .mclk(mclk),
    .rstn(rstn),
    .clr(start),
    .step(step),
    .size(st_r.src_size),
    .ptr(sptr),
    .ptr_nxt(sptr_nxt)
  );

  byte_pointer #(.PTR_W(16)) u_dst_ptr (
    .mclk(mclk),
    .rstn(rstn),
    .clr(start),
    .step(step),
    .size(st_r.dst_size),
    .ptr(dptr),
    .ptr_nxt(dptr_nxt)
  );

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Unmapped offsets read zero; reserved bits are always zero
  function automatic logic [31:0] read_word(input dma_chan_pkg::chan_state_t s, input logic [15:0] dp,
                                            input logic bsy);
    logic [31:0] w;
    w = dma_chan_pkg::RST_WORD;
    unique case (s.addr)
      dma_chan_pkg::OFS_EVENT: begin
        w[dma_chan_pkg::NUM_FLAGS-1:0] = s.flags;
        w[dma_chan_pkg::EN_LSB +: dma_chan_pkg::NUM_FLAGS] = s.enables;
      end
      dma_chan_pkg::OFS_SRC_START: w = s.src_start;
      dma_chan_pkg::OFS_DST_START: w = s.dst_start;
      dma_chan_pkg::OFS_SRC_SIZE: w[15:0] = s.src_size;
      dma_chan_pkg::OFS_DST_SIZE: w[15:0] = s.dst_size;
      dma_chan_pkg::OFS_CELL_SIZE: w[15:0] = s.cell_size;
      dma_chan_pkg::OFS_CONTROL: begin
        w[dma_chan_pkg::CTL_START] = bsy;
        w[dma_chan_pkg::CTL_ABORT_EN] = s.abort_en;
        w[dma_chan_pkg::CTL_ABORT_NUM_LSB +: 8] = s.abort_num;
      end
      dma_chan_pkg::OFS_STATUS: begin
        w[15:0] = dp;
        w[dma_chan_pkg::STS_BUSY] = bsy;
      end
      default: w = dma_chan_pkg::RST_WORD;
    endcase
    return w;
  endfunction : read_word

  // ---------------------------------------------------------------
  // Shared decode terms
  // ---------------------------------------------------------------
  // Size zero means a full 64 KiB run, so the limit is 17 bits wide
  always_comb begin
    busy = (st_r.eng != dma_chan_pkg::ENG_IDLE);
    bus_wr = st_r.wr_pend;
    start = bus_wr && (st_r.addr == dma_chan_pkg::OFS_CONTROL) && hwdata[dma_chan_pkg::CTL_START] && !busy;
    // Abort and match end a run even in the cycle of an answer; the
    // pointers must not step then or the status word drifts from the moves
    abort_hit = busy && irq_valid && st_r.abort_en && (irq_num == st_r.abort_num);
    match_hit = busy && pattern_match;
    step = (st_r.eng == dma_chan_pkg::ENG_REQ) && mv_ack && !mv_err && !abort_hit && !match_hit;
    big_size = (st_r.src_size > st_r.dst_size) ? st_r.src_size : st_r.dst_size;
    // Either size at zero stands for 64 KiB and is then the larger one
    if (st_r.src_size == dma_chan_pkg::RST_HALF || st_r.dst_size == dma_chan_pkg::RST_HALF) begin
      lim = 17'h1_0000;
    end else begin
      lim = {1'b0, big_size};
    end
    total_inc = st_r.total + 17'h0_0001;
    cell_inc = {1'b0, st_r.cell_cnt} + 17'h0_0001;
    dptr_inc = {1'b0, dptr} + 17'h0_0001;
    // A zero dest size is a 64 KiB buffer, whose midpoint is 32 KiB
    if (st_r.dst_size == dma_chan_pkg::RST_HALF) begin
      half_pt = 17'h0_8000;
    end else begin
      half_pt = {2'b00, st_r.dst_size[15:1]};
    end
  end

  // ---------------------------------------------------------------
  // Next state: bus slave, engine, flags
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    ev = dma_chan_pkg::RST_FLAGS;

    // Address phase capture; reads take one wait state so the data
    // come from a register and see any write just finished
    st_nxt.wr_pend = hsel && hready && (htrans & dma_chan_pkg::HTRANS_NONSEQ_BIT) != 2'h0 && hwrite;
    st_nxt.rd_pend = hsel && hready && (htrans & dma_chan_pkg::HTRANS_NONSEQ_BIT) != 2'h0 && !hwrite;
    if (hready) begin
      st_nxt.addr = haddr[7:0];
    end
    st_nxt.hready = !st_nxt.rd_pend;
    if (st_r.rd_pend) begin
      st_nxt.hrdata = read_word(st_r, dptr, busy);
    end

    // Register writes; only whole words are supported
    // Status is read-only, so a write there falls to the default arm
    if (bus_wr) begin
      unique case (st_r.addr)
        dma_chan_pkg::OFS_EVENT: begin
          st_nxt.flags = hwdata[dma_chan_pkg::NUM_FLAGS-1:0];
          st_nxt.enables = hwdata[dma_chan_pkg::EN_LSB +: dma_chan_pkg::NUM_FLAGS];
        end
        dma_chan_pkg::OFS_SRC_START: st_nxt.src_start = hwdata;
        dma_chan_pkg::OFS_DST_START: st_nxt.dst_start = hwdata;
        dma_chan_pkg::OFS_SRC_SIZE: st_nxt.src_size = hwdata[15:0];
        dma_chan_pkg::OFS_DST_SIZE: st_nxt.dst_size = hwdata[15:0];
        dma_chan_pkg::OFS_CELL_SIZE: st_nxt.cell_size = hwdata[15:0];
        dma_chan_pkg::OFS_CONTROL: begin
          st_nxt.abort_en = hwdata[dma_chan_pkg::CTL_ABORT_EN];
          st_nxt.abort_num = hwdata[dma_chan_pkg::CTL_ABORT_NUM_LSB +: 8];
        end
        default: st_nxt.flags = st_nxt.flags;
      endcase
    end

    // Transfer engine
    // A start while busy is dropped; there is no software stop
    unique case (st_r.eng)
      dma_chan_pkg::ENG_IDLE: begin
        if (start) begin
          st_nxt.eng = dma_chan_pkg::ENG_REQ;
          st_nxt.mv_req = 1'b1;
          st_nxt.mv_addr.src_addr = st_r.src_start;
          st_nxt.mv_addr.dst_addr = st_r.dst_start;
          st_nxt.total = 17'h0_0000;
          st_nxt.cell_cnt = dma_chan_pkg::RST_HALF;
        end
      end
      dma_chan_pkg::ENG_REQ, dma_chan_pkg::ENG_GAP: begin
        // Abort beats a pattern match, which beats the byte answer
        if (abort_hit) begin
          st_nxt.eng = dma_chan_pkg::ENG_IDLE;
          st_nxt.mv_req = 1'b0;
          ev[dma_chan_pkg::FLG_ABORT] = 1'b1;
        end else if (match_hit) begin
          st_nxt.eng = dma_chan_pkg::ENG_IDLE;
          st_nxt.mv_req = 1'b0;
          ev[dma_chan_pkg::FLG_BLOCK] = 1'b1;
        end else if (st_r.eng == dma_chan_pkg::ENG_GAP) begin
          // One idle cycle between moves keeps each answer tied to one address
          st_nxt.eng = dma_chan_pkg::ENG_REQ;
          st_nxt.mv_req = 1'b1;
        end else if (mv_ack && mv_err) begin
          st_nxt.eng = dma_chan_pkg::ENG_IDLE;
          st_nxt.mv_req = 1'b0;
          ev[dma_chan_pkg::FLG_ADDR_ERR] = 1'b1;
        end else if (step) begin
          st_nxt.mv_req = 1'b0;
          st_nxt.total = total_inc;
          st_nxt.mv_addr.src_addr = st_r.src_start + {16'h0000, sptr_nxt};
          st_nxt.mv_addr.dst_addr = st_r.dst_start + {16'h0000, dptr_nxt};
          if (dptr_inc == half_pt) begin
            ev[dma_chan_pkg::FLG_DEST_HALF] = 1'b1;
          end
          if (cell_inc == {1'b0, st_r.cell_size}) begin
            ev[dma_chan_pkg::FLG_CELL] = 1'b1;
            st_nxt.cell_cnt = dma_chan_pkg::RST_HALF;
          end else begin
            st_nxt.cell_cnt = cell_inc[15:0];
          end
          if (total_inc == lim) begin
            ev[dma_chan_pkg::FLG_BLOCK] = 1'b1;
            st_nxt.eng = dma_chan_pkg::ENG_IDLE;
          end else begin
            st_nxt.eng = dma_chan_pkg::ENG_GAP;
          end
        end
      end
    endcase

    // Set wins over a software clear in the same cycle
    st_nxt.flags = st_nxt.flags | ev;
    st_nxt.irq = |(st_nxt.flags & st_nxt.enables);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset loads constants only, field by field
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r.wr_pend <= 1'b0;
      st_r.rd_pend <= 1'b0;
      st_r.addr <= dma_chan_pkg::RST_BYTE;
      st_r.hready <= 1'b1;
      st_r.hrdata <= dma_chan_pkg::RST_WORD;
      st_r.irq <= 1'b0;
      st_r.flags <= dma_chan_pkg::RST_FLAGS;
      st_r.enables <= dma_chan_pkg::RST_FLAGS;
      st_r.src_start <= dma_chan_pkg::RST_WORD;
      st_r.dst_start <= dma_chan_pkg::RST_WORD;
      st_r.src_size <= dma_chan_pkg::RST_HALF;
      st_r.dst_size <= dma_chan_pkg::RST_HALF;
      st_r.cell_size <= dma_chan_pkg::RST_HALF;
      st_r.abort_en <= 1'b0;
      st_r.abort_num <= dma_chan_pkg::RST_BYTE;
      st_r.eng <= dma_chan_pkg::ENG_IDLE;
      st_r.mv_req <= 1'b0;
      st_r.mv_addr <= {dma_chan_pkg::RST_WORD, dma_chan_pkg::RST_WORD};
      st_r.total <= 17'h0_0000;
      st_r.cell_cnt <= dma_chan_pkg::RST_HALF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Response is always OKAY
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Outputs straight from the state register
  // No output sees a combinational path from the bus inputs
  always_comb begin
    hreadyout = st_r.hready;
    hrdata = st_r.hrdata;
    mv_req = st_r.mv_req;
    mv_addr = st_r.mv_addr;
    chan_irq = st_r.irq;
  end

endmodule : dma_channel

// file: dma_chan_pkg.sv
package dma_chan_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_EVENT = 8'h00;
  localparam logic [7:0] OFS_SRC_START = 8'h04;
  localparam logic [7:0] OFS_DST_START = 8'h08;
  localparam logic [7:0] OFS_SRC_SIZE = 8'h0C;
  localparam logic [7:0] OFS_DST_SIZE = 8'h10;
  localparam logic [7:0] OFS_CELL_SIZE = 8'h14;
  localparam logic [7:0] OFS_CONTROL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FLG_DEST_HALF = 4;
  localparam int FLG_BLOCK = 3;
  localparam int FLG_CELL = 2;
  localparam int FLG_ABORT = 1;
  localparam int FLG_ADDR_ERR = 0;
  localparam int NUM_FLAGS = 5;
  localparam int EN_LSB = 16;
  localparam int CTL_START = 0;
  localparam int CTL_ABORT_EN = 1;
  localparam int CTL_ABORT_NUM_LSB = 8;
  localparam int STS_BUSY = 16;
  localparam int SIZE_BITS = 16;

  // ---------------------------------------------------------------
  // Reset values and the htrans NONSEQ bit mask
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_FLAGS = 5'h00;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  // Engine states, one-hot
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_REQ = 3'b010,
    ENG_GAP = 3'b100
  } eng_state_t;

  // One byte move handed to the system bus
  typedef struct packed {
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
  } move_req_t;

  // State of the channel, all but the byte pointers and hresp
  typedef struct packed {
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic hready;
    logic [31:0] hrdata;
    logic irq;
    logic [4:0] flags;
    logic [4:0] enables;
    logic [31:0] src_start;
    logic [31:0] dst_start;
    logic [15:0] src_size;
    logic [15:0] dst_size;
    logic [15:0] cell_size;
    logic abort_en;
    logic [7:0] abort_num;
    eng_state_t eng;
    logic mv_req;
    move_req_t mv_addr;
    logic [16:0] total;
    logic [15:0] cell_cnt;
  } chan_state_t;

endpackage : dma_chan_pkg

// file: byte_pointer.sv
`timescale 1ns/1ps
module byte_pointer #(
  parameter int PTR_W = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic step,
  input wire logic [PTR_W-1:0] size,
  output logic [PTR_W-1:0] ptr,
  output logic [PTR_W-1:0] ptr_nxt
);

  // ---------------------------------------------------------------
  // Byte pointer, wraps when it reaches the programmed size
  // ---------------------------------------------------------------
  if (PTR_W < 1 || PTR_W > 16) begin : g_chk
    $error("byte_pointer: PTR_W must be 1..16");
  end

  // Size zero matches only when ptr + 1 wraps to zero, so the pointer rolls over at full range
  always_comb begin
    ptr_nxt = ptr;
    if (clr) begin
      ptr_nxt = '0;
    end else if (step) begin
      if (ptr + PTR_W'(1) == size) begin
        ptr_nxt = '0;
      end else begin
        ptr_nxt = ptr + PTR_W'(1);
      end
    end
  end

  // Pointer register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ptr <= '0;
    end else begin
      ptr <= ptr_nxt;
    end
  end

endmodule : byte_pointer

// file: dma_channel_assertions.sv
`timescale 1ns/1ps
// ----
// Port-level checker for the channel
// ----
module dma_channel_assertions (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic irq_valid,
  input wire logic pattern_match,
  input wire logic mv_ack,
  input wire logic mv_err,
  input wire logic mv_req,
  input wire dma_chan_pkg::move_req_t mv_addr,
  input wire logic chan_irq
);
  logic wr_dp_r;
  logic take;
  logic cause;
  // Accepted request; anything that may set a flag
  assign take = hsel && hready && htrans[1];
  assign cause = mv_ack || pattern_match || irq_valid || wr_dp_r;
  // Write data phase, the only way software reaches the flags
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_dp_r <= 1'b0;
    end else begin
      wr_dp_r <= take && hwrite;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence rd_s; take && !hwrite; endsequence
  sequence halt_s; !mv_req [*4]; endsequence
  AST_READ_WAIT: assert property (rd_s |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  AST_SIZE_UPPER: assert property (rd_s ##0 haddr[7:0] == dma_chan_pkg::OFS_SRC_SIZE |=> ##1 hrdata[31:16] == 16'h0000)
    else $error("size upper bits set");
  AST_RESET_QUIET: assert property ($rose(rstn) |-> hreadyout && !mv_req && !chan_irq && hrdata == 32'h0000_0000)
    else $error("not quiet after reset");
  AST_MOVE_HOLD: assert property (mv_req && !mv_ack && !pattern_match && !irq_valid |=> mv_req && $stable(mv_addr))
    else $error("move request not held");
  AST_MOVE_DROP: assert property (mv_req && mv_ack |=> !mv_req) else $error("request kept after ack");
  AST_ERR_STOP: assert property (mv_req && mv_ack && mv_err |=> halt_s) else $error("moved after error");
  AST_MATCH_STOP: assert property (pattern_match |=> halt_s) else $error("moved after match");
  AST_IRQ_CAUSE: assert property ($rose(chan_irq) |-> $past(cause) || $past(cause, 2)) else $error("irq without event");
  AST_IRQ_CLEAR: assert property ($fell(chan_irq) |-> $past(wr_dp_r) || $past(wr_dp_r, 2))
    else $error("irq fell without write");
endmodule : dma_channel_assertions
bind dma_channel dma_channel_assertions chk_i (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .irq_valid(irq_valid), .pattern_match(pattern_match), .mv_ack(mv_ack), .mv_err(mv_err),
  .mv_req(mv_req), .mv_addr(mv_addr), .chan_irq(chan_irq));

// file: sys_bus_model.sv
`timescale 1ns/1ps
// ----
// System bus stand-in answering byte moves
// ----
module sys_bus_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] dly,
  input wire logic [31:0] bad_from,
  input wire logic mv_req,
  input wire dma_chan_pkg::move_req_t mv_addr,
  output logic mv_ack,
  output logic mv_err
);
  logic [1:0] cnt_r;
  logic junk_r;
  logic bad;
  // Moves at or above bad_from are acked with an error
  assign bad = (mv_addr.src_addr >= bad_from) || (mv_addr.dst_addr >= bad_from);
  // Error means nothing without ack, so it toggles then
  assign mv_err = mv_ack ? bad : junk_r;
  // One-cycle ack after dly wait cycles
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mv_ack <= 1'b0;
      cnt_r <= 2'h0;
      junk_r <= 1'b0;
    end else begin
      junk_r <= ~junk_r;
      mv_ack <= mv_req && !mv_ack && cnt_r >= dly;
      cnt_r <= (mv_req && !mv_ack && cnt_r < dly) ? cnt_r + 2'h1 : 2'h0;
    end
  end
endmodule : sys_bus_model

// file: dma_channel_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module dma_channel_test;
  localparam logic [31:0] BAD_FROM = 32'h8000_0000;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic irq_valid = 1'b0;
  logic pattern_match = 1'b0;
  logic rd_dp = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [1:0] dly = 2'h0;
  logic [7:0] irq_num = 8'h00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] seed = 32'h0000_003A;
  logic [31:0] hrdata, exp_w, w;
  logic hready, hreadyout, hresp, mv_ack, mv_err, mv_req, chan_irq;
  dma_chan_pkg::move_req_t mv_addr, exp_m;
  logic [31:0] rd_q[$];
  dma_chan_pkg::move_req_t mv_q[$];
  logic [31:0] evt[3] = '{32'h0000_0004, 32'h0004_0004, 32'h0004_0000};
  int n_errors = 0;
  int n_checks = 0;

  // ----
  // Clock, design and far side
  // ----
  always #5 mclk = ~mclk;
  assign hready = hreadyout;
  dma_channel dma_channel_i (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .irq_valid(irq_valid), .irq_num(irq_num), .pattern_match(pattern_match), .mv_ack(mv_ack),
    .mv_err(mv_err), .mv_req(mv_req), .mv_addr(mv_addr), .chan_irq(chan_irq));
  sys_bus_model sys_bus_model_i (.mclk(mclk), .rstn(rstn), .dly(dly), .bad_from(BAD_FROM), .mv_req(mv_req),
    .mv_addr(mv_addr), .mv_ack(mv_ack), .mv_err(mv_err));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Single AHB transfer; waits out every stall
  task automatic bus(input logic [7:0] a, input logic wt, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wt;
    htrans <= 2'h2;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  // Read with its expected word noted first
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(a, 1'b0, rnd());
  endtask : rd

  // One transfer of nb bytes; ev 1 match, 2 irq, 3 bad source
  task automatic xfer(input int ss, input int ds, input int cs, input int nb, input int k, input int ev,
                      input logic [7:0] num, input logic [15:0] ctl, input logic [31:0] en, input logic [31:0] flg);
    logic [31:0] sa;
    logic [31:0] da;
    sa = (ev == 3) ? BAD_FROM - 32'h0000_0002 : rnd() & 32'h3FFF_FFFF;
    da = rnd() & 32'h3FFF_FFFF;
    wr(dma_chan_pkg::OFS_SRC_START, sa);
    wr(dma_chan_pkg::OFS_DST_START, da);
    wr(dma_chan_pkg::OFS_SRC_SIZE, 32'(ss));
    wr(dma_chan_pkg::OFS_DST_SIZE, 32'(ds));
    wr(dma_chan_pkg::OFS_CELL_SIZE, 32'(cs));
    wr(dma_chan_pkg::OFS_EVENT, en);
    for (int i = 0; i < nb; i++) mv_q.push_back({sa + 32'(i % ss), da + 32'(i % ds)});
    dly <= 2'(rnd());
    irq_num <= num;
    wr(dma_chan_pkg::OFS_CONTROL, {16'h0000, ctl});
    if (ev == 1 || ev == 2) begin
      repeat (k) begin
        do @(posedge mclk); while (!(mv_req && mv_ack));
      end
      pattern_match <= (ev == 1);
      irq_valid <= (ev == 2);
      @(posedge mclk);
      pattern_match <= 1'b0;
      irq_valid <= 1'b0;
    end
    while (mv_q.size() != 0) @(posedge mclk);
    repeat (8) @(posedge mclk);
    rd(dma_chan_pkg::OFS_EVENT, en | flg);
    `CHK(chan_irq, |(en[20:16] & flg[4:0]))
    $display("transfer test done");
  endtask : xfer

  // Each finished read and each acked move against its oldest note
  always @(posedge mclk) begin
    if (rd_dp && hreadyout) begin
      exp_w = rd_q.pop_front();
      `CHK(hrdata, exp_w)
      `CHK(hresp, 1'b0)
    end
    if (mv_req && mv_ack) begin
      exp_m = mv_q.pop_front();
      `CHK(mv_addr, exp_m)
    end
    if (hsel && hready && htrans[1]) rd_dp <= !hwrite;
    else if (hreadyout) rd_dp <= 1'b0;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // Whole run needs several hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("ERROR t=%0t timeout", $time);
    complete_run();
  end

  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    rd(dma_chan_pkg::OFS_EVENT, 32'h0000_0000);
    rd(dma_chan_pkg::OFS_SRC_START, 32'h0000_0000);
    rd(dma_chan_pkg::OFS_DST_START, 32'h0000_0000);
    rd(dma_chan_pkg::OFS_SRC_SIZE, 32'h0000_0000);
    wr(8'h3C, rnd());
    rd(8'h3C, 32'h0000_0000);
    repeat (4) begin
      w = rnd();
      wr(dma_chan_pkg::OFS_SRC_START, w);
      rd(dma_chan_pkg::OFS_SRC_START, w);
      wr(dma_chan_pkg::OFS_DST_START, ~w);
      rd(dma_chan_pkg::OFS_DST_START, ~w);
      wr(dma_chan_pkg::OFS_SRC_SIZE, w);
      rd(dma_chan_pkg::OFS_SRC_SIZE, {16'h0000, w[15:0]});
    end
    $display("register test done");
    // Flag set by software: masked, enabled, then cleared
    foreach (evt[j]) begin
      wr(dma_chan_pkg::OFS_EVENT, evt[j]);
      rd(dma_chan_pkg::OFS_EVENT, evt[j]);
      `CHK(chan_irq, evt[j][2] & evt[j][18])
    end
    $display("flag test done");
    xfer(4, 8, 3, 8, 0, 0, 8'h00, 16'h0001, 32'h001F_0000, 32'h0000_001C);
    xfer(9, 3, 0, 9, 0, 0, 8'h00, 16'h0001, 32'h0000_0000, 32'h0000_0018);
    xfer(20, 20, 0, 3, 3, 1, 8'h00, 16'h0001, 32'h0008_0000, 32'h0000_0008);
    xfer(6, 6, 0, 6, 2, 2, 8'h5A, 16'h5A01, 32'h0002_0000, 32'h0000_0018);
    xfer(6, 6, 0, 6, 2, 2, 8'h5B, 16'h5A03, 32'h0002_0000, 32'h0000_0018);
    xfer(20, 20, 0, 2, 2, 2, 8'h5A, 16'h5A03, 32'h0002_0000, 32'h0000_0002);
    xfer(4, 16, 0, 3, 0, 3, 8'h00, 16'h0001, 32'h0001_0000, 32'h0000_0001);
    rd(dma_chan_pkg::OFS_STATUS, 32'h0000_0002);
    complete_run();
  end
endmodule : dma_channel_test
